// ==== rfq_pkg.sv ====
/*
 Constants, register map and state types of the reader byte queue block.
 Assumes a 100 MHz core clock and the host as master of the parallel port.
*/
`default_nettype none
package rfq_pkg;
   // ------------------------------------------------------------
   // Register map and word layout.
   // ------------------------------------------------------------
   localparam logic [4:0] ADDR_IRQ_STATUS = 5'h0C;
   localparam logic [4:0] ADDR_IRQ_MASK = 5'h0D;
   localparam logic [4:0] ADDR_QSTAT = 5'h1C;
   localparam logic [4:0] ADDR_TXLEN_HI = 5'h1D;
   localparam logic [4:0] ADDR_TXLEN_LO = 5'h1E;
   localparam logic [4:0] ADDR_QDATA = 5'h1F;
   localparam logic [4:0] CMD_RESET = 5'h0F;
   localparam int AW_CMD_BIT = 7;
   localparam int AW_READ_BIT = 6;
   localparam int AW_CONT_BIT = 5;
   // ------------------------------------------------------------
   // Queue geometry, levels and status bits.
   // ------------------------------------------------------------
   localparam logic [3:0] QDEPTH = 4'hC;
   localparam logic [3:0] QLAST = 4'hB;
   localparam logic [3:0] LOW_LEVEL = 4'h3;
   localparam logic [3:0] HIGH_LEVEL = 4'h9;
   localparam int QS_OVF_BIT = 4;
   localparam int QS_LOW_BIT = 5;
   localparam int QS_HIGH_BIT = 6;
   localparam logic [12:0] SHORT_TX_BYTES = 13'h0004;
   // ------------------------------------------------------------
   // Interrupt cause bits.
   // ------------------------------------------------------------
   localparam int IRQ_TX_BIT = 7;
   localparam int IRQ_RX_BIT = 6;
   localparam int IRQ_QLEVEL_BIT = 5;
   localparam int IRQ_CRC_BIT = 4;
   localparam int IRQ_FRAME_BIT = 3;
   // ------------------------------------------------------------
   // Straps and timing.
   // ------------------------------------------------------------
   localparam logic [2:0] STRAP_SPI_SS = 3'h6;
   localparam logic [1:0] STRAP_WAIT = 2'h3;
   localparam int CLK_PERIOD_NS = 10;
   localparam int TX_BYTE_TIME_NS = 151000;
   localparam int TX_BYTE_CYCLES = TX_BYTE_TIME_NS / CLK_PERIOD_NS;
   typedef enum logic [2:0] {IF_IDLE, IF_ADDR, IF_WRITE, IF_READ, IF_HOLD} rfq_if_state_t;
endpackage
`default_nettype wire

// ==== rfq_reader_queue.sv ====
/*
 Byte queue, transmit length counters, interrupt causes and parallel host
 port of the reader front end. Assumes the host clocks the port on
 data_clk_i and that the modem logic uses core_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [RULE1] Twelve-byte circular queue at one register address.
// [RULE2] Reset command empties the queue.
// [RULE3] Status bits 3..0 show stored bytes minus one.
// [RULE4] Twelve-bit length counter decides when end-of-frame is sent.
// [RULE5] Low length register bits 3..0 count bits of a trailing byte.
// [RULE6] Status bit 4 flags a write into a full queue.
// [RULE7] Status bit 5 flags three or fewer bytes left while sending.
// [RULE8] Status bit 6 flags nine or more stored bytes.
// [RULE9] Host loads at most twelve bytes per sequence, refilling long frames.
// [RULE10] Interrupt when queue falls to three or rises to nine bytes.
// [RULE11] Sending starts at first queue write after lengths are set.
// [RULE12] Data bit 7 rising with clock high starts and resets interface.
// [RULE13] Data bit 7 falling with clock high stops and ends direct mode.
// [RULE14] Rise then fall with clock low resets the parallel interface.
// [RULE15] Host sends an address word first, then data bytes.
// [RULE16] Frame start sets cause bit 6; short frames interrupt at end only.
// [RULE17] Long received frames interrupt as ninth byte enters queue.
// [RULE18] Receive errors set framing or checksum cause flags.
// [RULE19] Host clears queue, then writes lengths and data in one stream.
// [RULE20] Sending start sets cause bit 7.
// [RULE21] Frames of five bytes or more also interrupt at level three.
// [RULE22] Unequal straps at power-up select a serial variant.
// [RULE23] Interrupt line holds until cause register is read and cleared.
// [RULE24] First word: bit 7 command, bit 6 read, bit 5 increment.
// [RULE25] Increment mode advances the address after each data byte.
// [RULE26] Flags and counter follow every push and pop.
module rfq_reader_queue
   import rfq_pkg::*;
#(
   parameter int TX_CYCLES = TX_BYTE_CYCLES
)
(
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic data_clk_i,
   input wire logic [7:0] io_i,
   output logic [7:0] io_o,
   output logic [7:0] io_oe_o,
   output logic irq_o,
   input wire logic rx_sof_i,
   input wire logic rx_byte_valid_i,
   input wire logic [7:0] rx_byte_i,
   input wire logic rx_end_i,
   input wire logic rx_crc_err_i,
   input wire logic rx_frame_err_i,
   input wire logic direct_enter_i,
   output logic [7:0] tx_byte_o,
   output logic tx_valid_o,
   output logic tx_eof_o,
   output logic spi_mode_o,
   output logic spi_ss_sel_o,
   output logic direct_mode_o
);
   // ------------------------------------------------------------
   // State of both domains.
   // ------------------------------------------------------------
   typedef struct packed {
      logic rst_m;
      logic rst_q;
      logic [1:0][7:0] slot;
      logic tog;
   } rfq_link_t;

   typedef struct packed {
      logic clk_m;
      logic clk_q;
      logic d7_m;
      logic d7_q;
      logic d7_prev;
      logic tog_m;
      logic tog_q;
      logic tog_prev;
      logic pend;
      logic [7:0] pend_byte;
      logic [2:0] strap_m;
      logic [2:0] strap_q;
      logic [1:0] strap_wait;
      logic straps_done;
      logic spi_mode;
      logic spi_ss;
      logic direct;
      rfq_if_state_t st;
      logic [4:0] addr;
      logic cont;
      logic cstop_armed;
      logic [11:0][7:0] mem;
      logic [3:0] wr_ptr;
      logic [3:0] rd_ptr;
      logic [3:0] count;
      logic ovf;
      logic [7:0] len_hi;
      logic [7:0] len_lo;
      logic len_set;
      logic tx_active;
      logic [12:0] tx_sent;
      logic [15:0] tx_pace;
      logic [7:0] irq_stat;
      logic [7:0] irq_mask;
      logic stat_read;
      logic irq_q;
      logic [7:0] io_out;
      logic [7:0] io_oe;
      logic [7:0] tx_byte;
      logic tx_valid;
      logic tx_eof;
   } rfq_core_t;

   rfq_link_t l_reg;
   rfq_link_t l_next;
   rfq_core_t s;
   rfq_core_t n;
   logic par_en;
   logic start_ev;
   logic sstop_ev;
   logic cstop_ev;
   logic byte_ev;
   logic byte_go;
   logic [4:0] nxt_addr;
   logic [7:0] byte_w;
   logic [12:0] tx_total;
   logic host_push;
   logic host_pop;
   logic tx_pop;
   logic rx_push;
   logic q_clr;

   // ------------------------------------------------------------
   // Link domain: one byte per host clock into alternating slots.
   // ------------------------------------------------------------
   always_comb
   begin
      l_next = l_reg;
      l_next.rst_m = sys_rst_i;
      l_next.rst_q = l_reg.rst_m;
      if (l_reg.rst_q)
      begin
         l_next.slot = '0;
         l_next.tog = 1'b0;
      end
      else
      begin
         l_next.slot[~l_reg.tog] = io_i;
         l_next.tog = ~l_reg.tog;
      end
   end

   always_ff @(posedge data_clk_i)
   begin
      l_reg <= l_next;
   end

   // ------------------------------------------------------------
   // Frame conditions seen from the core domain.
   // ------------------------------------------------------------
   assign par_en = s.straps_done & ~s.spi_mode;
   assign start_ev = par_en & s.d7_q & ~s.d7_prev & s.clk_q; // [RULE12]
   assign sstop_ev = par_en & ~s.d7_q & s.d7_prev & s.clk_q; // [RULE13]
   assign cstop_ev = par_en & ~s.d7_q & s.d7_prev & ~s.clk_q & s.cstop_armed; // [RULE14]
   assign byte_ev = par_en & (s.tog_q != s.tog_prev);
   // A byte counts only once the host clock falls, so the clock of a stop adds none.
   assign byte_go = par_en & s.pend & ~s.clk_q;
   assign byte_w = s.pend_byte;
   assign nxt_addr = (s.addr == ADDR_QDATA) ? ADDR_QDATA : s.addr + 5'h01; // [RULE25]
   assign tx_total = {1'b0, s.len_hi, s.len_lo[7:4]} + {12'h000, |s.len_lo[3:0]}; // [RULE4] [RULE5]

   function automatic logic [7:0] reg_value(input rfq_core_t c, input logic [4:0] a);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         ADDR_IRQ_STATUS: v = c.irq_stat;
         ADDR_IRQ_MASK: v = c.irq_mask;
         ADDR_QSTAT:
         begin
            v[3:0] = c.count - 4'h1; // [RULE3]
            v[QS_OVF_BIT] = c.ovf; // [RULE6]
            v[QS_LOW_BIT] = c.tx_active & (c.count <= LOW_LEVEL); // [RULE7]
            v[QS_HIGH_BIT] = c.count >= HIGH_LEVEL; // [RULE8]
         end
         ADDR_TXLEN_HI: v = c.len_hi;
         ADDR_TXLEN_LO: v = c.len_lo;
         ADDR_QDATA: v = c.mem[c.rd_ptr];
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // ------------------------------------------------------------
   // Core domain next state.
   // ------------------------------------------------------------
   always_comb
   begin
      n = s;
      host_push = 1'b0;
      host_pop = 1'b0;
      tx_pop = 1'b0;
      q_clr = 1'b0;
      rx_push = rx_byte_valid_i;
      n.tx_valid = 1'b0;
      n.tx_eof = 1'b0;
      n.clk_m = data_clk_i;
      n.clk_q = s.clk_m;
      n.d7_m = io_i[7];
      n.d7_q = s.d7_m;
      n.d7_prev = s.d7_q;
      n.tog_m = l_reg.tog;
      n.tog_q = s.tog_m;
      n.tog_prev = s.tog_q;
      n.strap_m = io_i[2:0];
      n.strap_q = s.strap_m;
      if (!s.straps_done)
      begin
         if (s.strap_wait == STRAP_WAIT)
         begin
            n.straps_done = 1'b1;
            n.spi_mode = (s.strap_q != 3'h0) && (s.strap_q != 3'h7); // [RULE22]
            n.spi_ss = s.strap_q == STRAP_SPI_SS;
         end
         else
         begin
            n.strap_wait = s.strap_wait + 2'h1;
         end
      end
      n.cstop_armed = par_en & ~s.clk_q & (s.cstop_armed | (s.d7_q & ~s.d7_prev));
      if (direct_enter_i)
      begin
         n.direct = 1'b1;
      end
      if (start_ev)
      begin
         n.st = IF_ADDR; // [RULE12]
         n.io_oe = 8'h00;
         n.pend = 1'b0;
      end
      else if (sstop_ev || cstop_ev)
      begin
         n.st = IF_IDLE; // [RULE14]
         n.io_oe = 8'h00;
         n.pend = 1'b0;
         if (sstop_ev)
         begin
            n.direct = 1'b0; // [RULE13]
         end
         if (s.stat_read)
         begin
            n.irq_stat = 8'h00; // [RULE23]
            n.irq_q = 1'b0;
            n.stat_read = 1'b0;
         end
      end
      else if (byte_ev)
      begin
         n.pend = 1'b1;
         n.pend_byte = l_reg.slot[s.tog_q];
      end
      else if (byte_go)
      begin
         n.pend = 1'b0;
         case (s.st)
            IF_ADDR:
            begin
               if (byte_w[AW_CMD_BIT]) // [RULE24]
               begin
                  if (byte_w[4:0] == CMD_RESET)
                  begin
                     q_clr = 1'b1; // [RULE2]
                  end
               end
               else
               begin
                  n.addr = byte_w[4:0];
                  n.cont = byte_w[AW_CONT_BIT];
                  if (byte_w[AW_READ_BIT])
                  begin
                     n.st = IF_READ;
                     n.io_out = reg_value(s, byte_w[4:0]);
                     n.io_oe = 8'hFF;
                     host_pop = byte_w[4:0] == ADDR_QDATA;
                     n.stat_read = s.stat_read | (byte_w[4:0] == ADDR_IRQ_STATUS);
                  end
                  else
                  begin
                     n.st = IF_WRITE;
                  end
               end
            end
            IF_WRITE:
            begin
               case (s.addr)
                  ADDR_IRQ_MASK: n.irq_mask = byte_w;
                  ADDR_TXLEN_HI: n.len_hi = byte_w;
                  ADDR_TXLEN_LO: n.len_lo = byte_w;
                  ADDR_QDATA: host_push = 1'b1;
                  default: n.len_set = s.len_set;
               endcase
               if (s.addr == ADDR_TXLEN_HI || s.addr == ADDR_TXLEN_LO)
               begin
                  n.len_set = 1'b1;
               end
               if (s.cont)
               begin
                  n.addr = nxt_addr; // [RULE25]
               end
               else
               begin
                  n.st = IF_HOLD;
               end
            end
            IF_READ:
            begin
               if (s.cont)
               begin
                  n.addr = nxt_addr; // [RULE25]
                  n.io_out = reg_value(s, nxt_addr);
                  host_pop = nxt_addr == ADDR_QDATA;
                  n.stat_read = s.stat_read | (nxt_addr == ADDR_IRQ_STATUS);
               end
               else
               begin
                  n.io_oe = 8'h00;
                  n.st = IF_HOLD;
               end
            end
            IF_IDLE, IF_HOLD: n.st = s.st;
            default: n.st = IF_IDLE;
         endcase
      end
      if (host_push && s.len_set && !s.tx_active)
      begin
         n.tx_active = 1'b1; // [RULE11]
         n.irq_stat[IRQ_TX_BIT] = 1'b1; // [RULE20]
         n.len_set = 1'b0;
         n.tx_sent = 13'h0000;
         n.tx_pace = 16'h0000;
      end
      else if (s.tx_active)
      begin
         if (s.tx_pace == 16'(TX_CYCLES - 1))
         begin
            n.tx_pace = 16'h0000;
            if (s.count != 4'h0 && !host_pop)
            begin
               tx_pop = 1'b1;
               n.tx_byte = s.mem[s.rd_ptr];
               n.tx_valid = 1'b1;
               n.tx_sent = s.tx_sent + 13'h0001;
               if (s.tx_sent + 13'h0001 == tx_total)
               begin
                  n.tx_eof = 1'b1; // [RULE4]
                  n.tx_active = 1'b0;
                  n.irq_q = 1'b1; // [RULE21]
               end
            end
         end
         else
         begin
            n.tx_pace = s.tx_pace + 16'h0001;
         end
      end
      if (q_clr)
      begin
         n.wr_ptr = 4'h0;
         n.rd_ptr = 4'h0;
         n.count = 4'h0;
         n.ovf = 1'b0;
         n.tx_active = 1'b0;
         n.len_set = 1'b0;
      end
      else
      begin
         if ((host_push || rx_push) && s.count == QDEPTH)
         begin
            n.ovf = 1'b1; // [RULE6]
         end
         else if (host_push || rx_push)
         begin
            n.mem[s.wr_ptr] = host_push ? byte_w : rx_byte_i; // [RULE1]
            n.wr_ptr = (s.wr_ptr == QLAST) ? 4'h0 : s.wr_ptr + 4'h1;
            n.count = n.count + 4'h1; // [RULE26]
         end
         if ((host_pop || tx_pop) && s.count != 4'h0)
         begin
            n.rd_ptr = (s.rd_ptr == QLAST) ? 4'h0 : s.rd_ptr + 4'h1;
            n.count = n.count - 4'h1; // [RULE26]
         end
      end
      if (s.tx_active && tx_total > SHORT_TX_BYTES && n.count == LOW_LEVEL
          && s.count > LOW_LEVEL)
      begin
         n.irq_stat[IRQ_QLEVEL_BIT] = 1'b1; // [RULE21] [RULE10]
         n.irq_q = 1'b1;
      end
      if (rx_push && !host_push && n.count == HIGH_LEVEL && s.count != HIGH_LEVEL)
      begin
         n.irq_stat[IRQ_QLEVEL_BIT] = 1'b1; // [RULE17] [RULE10]
         n.irq_q = 1'b1;
      end
      if (rx_sof_i)
      begin
         n.irq_stat[IRQ_RX_BIT] = 1'b1; // [RULE16]
      end
      if (rx_end_i)
      begin
         n.irq_q = 1'b1; // [RULE16]
      end
      if (rx_crc_err_i || rx_frame_err_i)
      begin
         n.irq_stat[IRQ_CRC_BIT] = s.irq_stat[IRQ_CRC_BIT] | rx_crc_err_i; // [RULE18]
         n.irq_stat[IRQ_FRAME_BIT] = s.irq_stat[IRQ_FRAME_BIT] | rx_frame_err_i;
         n.irq_q = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         s <= '0;
      end
      else
      begin
         s <= n;
      end
   end

   assign io_o = s.io_out;
   assign io_oe_o = s.io_oe;
   assign irq_o = s.irq_q;
   assign tx_byte_o = s.tx_byte;
   assign tx_valid_o = s.tx_valid;
   assign tx_eof_o = s.tx_eof;
   assign spi_mode_o = s.spi_mode;
   assign spi_ss_sel_o = s.spi_ss;
   assign direct_mode_o = s.direct;

   // ------------------------------------------------------------
   // Checks.
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   property p_depth;
      s.count <= QDEPTH && s.wr_ptr <= QLAST && s.rd_ptr <= QLAST;
   endproperty
   a_depth: assert property (p_depth) else $error("queue depth out of range"); // [RULE1]

   property p_reset_cmd;
      byte_go && !start_ev && !sstop_ev && !cstop_ev && s.st == IF_ADDR
      && byte_w == {1'b1, 2'b00, CMD_RESET} |=> s.count == 4'h0;
   endproperty
   a_reset_cmd: assert property (p_reset_cmd) else $error("reset command left bytes"); // [RULE2]

   property p_overflow;
      rx_push && !q_clr && !host_pop && !tx_pop && s.count == QDEPTH
      |=> s.ovf && s.count == QDEPTH;
   endproperty
   a_overflow: assert property (p_overflow) else $error("overflow not flagged"); // [RULE6]

   property p_tx_start;
      host_push && s.len_set && !s.tx_active && !q_clr
      |=> s.tx_active && s.irq_stat[IRQ_TX_BIT] && s.tx_sent == 13'h0000;
   endproperty
   a_tx_start: assert property (p_tx_start) else $error("send did not start"); // [RULE11] [RULE20]

   property p_short_tx;
      s.tx_active && tx_total <= SHORT_TX_BYTES && !s.irq_q && !rx_end_i
      && !rx_crc_err_i && !rx_frame_err_i && !rx_push |=> !s.irq_q || !s.tx_active;
   endproperty
   a_short_tx: assert property (p_short_tx) else $error("early send interrupt"); // [RULE21]

   property p_irq_hold;
      s.irq_q && !((sstop_ev || cstop_ev) && s.stat_read) |=> s.irq_q;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped"); // [RULE23]

   property p_start;
      start_ev |=> s.st == IF_ADDR && s.io_oe == 8'h00;
   endproperty
   a_start: assert property (p_start) else $error("start not taken"); // [RULE12]

   property p_incr;
      byte_go && !start_ev && !sstop_ev && !cstop_ev && s.st == IF_WRITE && s.cont
      && s.addr != ADDR_QDATA |=> s.addr == $past(s.addr) + 5'h01;
   endproperty
   a_incr: assert property (p_incr) else $error("address not advanced"); // [RULE25]

   property p_qdata_hold;
      byte_go && !start_ev && !sstop_ev && !cstop_ev && s.st == IF_WRITE && s.cont
      && s.addr == ADDR_QDATA |=> s.addr == ADDR_QDATA;
   endproperty
   a_qdata_hold: assert property (p_qdata_hold) else $error("queue address moved"); // [RULE1]

   property p_rx_high;
      rx_push && !host_push && !q_clr && s.count == 4'h8 && !host_pop && !tx_pop
      |=> s.irq_q && s.irq_stat[IRQ_QLEVEL_BIT];
   endproperty
   a_rx_high: assert property (p_rx_high) else $error("ninth byte missed"); // [RULE17]

   property p_errors;
      rx_crc_err_i |=> s.irq_stat[IRQ_CRC_BIT] && s.irq_q;
   endproperty
   a_errors: assert property (p_errors) else $error("error flag missing"); // [RULE18]
endmodule
`default_nettype wire

// ==== rfq_host_model.sv ====
/*
 Host model for the parallel port: start, stops, byte writes and reads.
 Assumes the reader drives a pin only while its enable bit is high.
*/
`timescale 1ns/1ps
`default_nettype none
module rfq_host_model
(
   input wire logic core_clk_i,
   input wire logic [7:0] io_o,
   input wire logic [7:0] io_oe_o,
   output logic data_clk_o,
   output logic [7:0] pins_o,
   output logic rd_valid_o,
   output logic [7:0] rd_data_o
);
   logic [7:0] drv;
   logic [7:0] fill;
   logic hz;
   logic stopping;
   // ------------------------------------------------------------
   // Pin levels; released lines toggle every cycle.
   // ------------------------------------------------------------
   initial
   begin
      data_clk_o = 1'b0;
      rd_valid_o = 1'b0;
      rd_data_o = 8'h00;
      drv = 8'h00;
      fill = 8'h5A;
      hz = 1'b0;
      stopping = 1'b0;
   end
   always @(posedge core_clk_i) fill <= ~fill;
   always_comb
   begin
      pins_o = hz ? {drv[7], fill[6:0]} : drv;
      for (int i = 0; i < 8; i++)
      begin
         if (io_oe_o[i] && !(i == 7 && stopping))
         begin
            pins_o[i] = io_o[i];
         end
      end
   end
   // ------------------------------------------------------------
   // Frame tasks; the clock stands still between frames.
   // ------------------------------------------------------------
   task automatic edge_clk();
      #15 data_clk_o = 1'b1;
      #15 data_clk_o = 1'b0;
   endtask
   task automatic start();
      hz = 1'b0;
      stopping = 1'b0;
      drv = 8'h00;
      #30 data_clk_o = 1'b1;
      #30 drv[7] = 1'b1;
      #30 data_clk_o = 1'b0;
   endtask
   task automatic put(input logic [7:0] b);
      #5 drv = b;
      #10 data_clk_o = 1'b1;
      #15 data_clk_o = 1'b0;
   endtask
   task automatic stop(input logic cont);
      stopping = 1'b1;
      hz = 1'b0;
      if (cont)
      begin
         #30 drv[7] = 1'b0;
         #30 drv[7] = 1'b1;
         #30 drv[7] = 1'b0;
      end
      else
      begin
         #30 drv[7] = 1'b1;
         #30 data_clk_o = 1'b1;
         #30 drv[7] = 1'b0;
         #30 data_clk_o = 1'b0;
      end
      #60;
   endtask
   task automatic get(input int n);
      hz = 1'b1;
      for (int k = 0; k < n; k++)
      begin
         if (k > 0)
         begin
            edge_clk();
         end
         repeat (8) @(posedge core_clk_i);
         rd_valid_o <= 1'b1;
         rd_data_o <= pins_o;
         @(posedge core_clk_i);
         rd_valid_o <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// ==== rfq_reader_queue_tb_top.sv ====
/*
 Self-checking bench of the reader byte queue, driven through a host model.
 Assumes a short air byte time so that frames finish quickly.
*/
`timescale 1ns/1ps
`default_nettype none
module rfq_reader_queue_tb_top
   import rfq_pkg::*;
;
   logic core_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic rx_sof_i = 1'b0, rx_byte_valid_i = 1'b0, rx_end_i = 1'b0;
   logic rx_crc_err_i = 1'b0, rx_frame_err_i = 1'b0, direct_enter_i = 1'b0;
   logic [7:0] rx_byte_i = 8'h00;
   logic data_clk, irq_o, tx_valid_o, tx_eof_o, spi_mode_o, spi_ss_sel_o;
   logic direct_mode_o, rd_valid;
   logic [7:0] pins, io_o, io_oe_o, tx_byte_o, rd_data;
   logic [15:0] exp_rd[$];
   logic [15:0] exp_tx[$];
   int errors = 0;
   int checked = 0;
   always #5 core_clk_i = ~core_clk_i;
   rfq_reader_queue #(.TX_CYCLES(8)) dut
   (
      .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .data_clk_i(data_clk),
      .io_i(pins), .io_o(io_o), .io_oe_o(io_oe_o), .irq_o(irq_o),
      .rx_sof_i(rx_sof_i), .rx_byte_valid_i(rx_byte_valid_i), .rx_byte_i(rx_byte_i),
      .rx_end_i(rx_end_i), .rx_crc_err_i(rx_crc_err_i), .rx_frame_err_i(rx_frame_err_i),
      .direct_enter_i(direct_enter_i), .tx_byte_o(tx_byte_o), .tx_valid_o(tx_valid_o),
      .tx_eof_o(tx_eof_o), .spi_mode_o(spi_mode_o), .spi_ss_sel_o(spi_ss_sel_o),
      .direct_mode_o(direct_mode_o)
   );
   rfq_host_model host
   (
      .core_clk_i(core_clk_i), .io_o(io_o), .io_oe_o(io_oe_o), .data_clk_o(data_clk),
      .pins_o(pins), .rd_valid_o(rd_valid), .rd_data_o(rd_data)
   );
   // ------------------------------------------------------------
   // Checking and closing.
   // ------------------------------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      if (errors == 0 && checked > 0)
      begin
         $display("verification passed");
      end
      else
      begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic drain();
      int n;
      n = 0;
      while (exp_tx.size() + exp_rd.size() != 0)
      begin
         @(posedge core_clk_i);
         n++;
         if (n > 3000)
         begin
            errors++;
            print_verdict();
         end
      end
   endtask
   always @(posedge core_clk_i)
   begin
      if (rd_valid === 1'b1)
      begin
         chk({8'h00, rd_data}, exp_rd.pop_front());
      end
      if (tx_valid_o === 1'b1)
      begin
         chk({7'h00, tx_eof_o, tx_byte_o}, exp_tx.pop_front());
      end
   end
   // ------------------------------------------------------------
   // Host transfers and reset.
   // ------------------------------------------------------------
   task automatic wr(input logic [7:0] aw, input logic [7:0] d[$]);
      host.start();
      host.put(aw);
      foreach (d[k]) host.put(d[k]);
      host.stop(1'b0);
   endtask
   task automatic rdn(input logic [7:0] aw, input int n, input logic cont);
      host.start();
      host.put(aw);
      host.get(n);
      host.stop(cont);
      drain();
   endtask
   task automatic rd1(input logic [7:0] aw, input logic [7:0] exp, input logic cont);
      exp_rd.push_back({8'h00, exp});
      rdn(aw, 1, cont);
   endtask
   task automatic rst(input logic [2:0] s);
      @(posedge core_clk_i);
      host.drv = {5'h00, s};
      sys_rst_i <= 1'b1;
      fork
         repeat (4) host.edge_clk();
      join_none
      repeat (20) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      repeat (2) host.edge_clk();
      repeat (10) @(posedge core_clk_i);
      chk({6'h00, irq_o, direct_mode_o, io_oe_o}, 16'h0000);
   endtask
   // ------------------------------------------------------------
   // Main sequence.
   // ------------------------------------------------------------
   initial
   begin
      logic [7:0] b;
      logic [7:0] q[$];
      logic [7:0] nil[$];
      logic [2:0] straps[4] = '{3'h6, 3'h3, 3'h7, 3'h0};
      void'($urandom(88));
      foreach (straps[k])
      begin
         rst(straps[k]);
         chk({14'h0000, spi_mode_o, spi_ss_sel_o}, {14'h0000, straps[k] != 3'h0
            && straps[k] != 3'h7, straps[k] == STRAP_SPI_SS});
      end
      wr({3'h4, CMD_RESET}, nil);
      rd1({3'h2, ADDR_QSTAT}, 8'h0F, 1'b0);
      rd1(8'h41, 8'h00, 1'b1);
      q = {8'hAB, 8'hC5};
      wr({3'h1, ADDR_TXLEN_HI}, q);
      exp_rd = {16'h00AB, 16'h00C5};
      rdn({3'h3, ADDR_TXLEN_HI}, 2, 1'b0);
      @(posedge core_clk_i) direct_enter_i <= 1'b1;
      @(posedge core_clk_i) direct_enter_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      chk(16'(direct_mode_o), 16'h0001);
      host.start();
      host.stop(1'b0);
      chk(16'(direct_mode_o), 16'h0000);
      q.delete();
      @(posedge core_clk_i) rx_sof_i <= 1'b1;
      @(posedge core_clk_i) rx_sof_i <= 1'b0;
      for (int k = 1; k <= 13; k++)
      begin
         b = 8'($urandom());
         if (k <= 12) q.push_back(b);
         rx_byte_i <= b;
         rx_byte_valid_i <= 1'b1;
         @(posedge core_clk_i) rx_byte_valid_i <= 1'b0;
         repeat (3) @(posedge core_clk_i);
         if (k == 8 || k == 9) chk(16'(irq_o), 16'(k == 9));
      end
      rd1({3'h2, ADDR_QSTAT}, 8'h5B, 1'b0);
      rd1({3'h2, ADDR_IRQ_STATUS}, 8'h60, 1'b0);
      chk(16'(irq_o), 16'h0000);
      foreach (q[k]) exp_rd.push_back({8'h00, q[k]});
      rdn({3'h3, ADDR_QDATA}, 12, 1'b0);
      rd1({3'h2, ADDR_QSTAT}, 8'h1F, 1'b0);
      wr({3'h4, CMD_RESET}, nil);
      rd1({3'h2, ADDR_QSTAT}, 8'h0F, 1'b0);
      @(posedge core_clk_i) {rx_crc_err_i, rx_frame_err_i, rx_end_i} <= 3'h7;
      @(posedge core_clk_i) {rx_crc_err_i, rx_frame_err_i, rx_end_i} <= 3'h0;
      repeat (3) @(posedge core_clk_i);
      chk(16'(irq_o), 16'h0001);
      rd1({3'h2, ADDR_IRQ_STATUS}, 8'h18, 1'b0);
      for (int f = 0; f < 2; f++)
      begin
         q = {8'h00, (f == 1) ? 8'h60 : 8'h35};
         for (int k = 0; k < ((f == 1) ? 6 : 4); k++)
         begin
            b = 8'($urandom()) & 8'h7F;
            q.push_back(b);
            exp_tx.push_back({7'h00, k == ((f == 1) ? 5 : 3), b});
         end
         wr({3'h1, ADDR_TXLEN_HI}, q);
         drain();
         repeat (4) @(posedge core_clk_i);
         chk(16'(irq_o), 16'h0001);
         rd1({3'h2, ADDR_IRQ_STATUS}, (f == 1) ? 8'hA0 : 8'h80, 1'b0);
      end
      print_verdict();
   end
endmodule
`default_nettype wire
